// ### hdl/sensor_setup_defines.vh
// Register map, reset values and timing constants of the PLL and output setup block
`ifndef SENSOR_SETUP_DEFINES_VH
`define SENSOR_SETUP_DEFINES_VH

// Register banks
`define BANK_SEQ 3'h0
`define BANK_CFG 3'h1
`define BANK_CTX 3'h4

// Register addresses within their bank
`define ADDR_COLOUR_SELECT 7'h04
`define ADDR_OUTPUT_FORMAT 7'h08
`define ADDR_BYTE_CLK_HIGH 7'h08
`define ADDR_BYTE_CLK_LOW 7'h09
`define ADDR_USED_CHANNELS 7'h0E
`define ADDR_SYNTH_POWER_UP 7'h4D
`define ADDR_SYNTH_FB_MULT 7'h4E
`define ADDR_SYNTH_CORE_RST 7'h50
`define ADDR_SYNTH_LOCK 7'h55
`define ADDR_CONV_CLK_DIV 7'h56
`define ADDR_MAIN_OUT_DIV 7'h57
`define ADDR_SYNTH_WRAP_RST 7'h58
`define ADDR_REGULATOR 7'h73
`define ADDR_COLOUR_PATTERN 7'h76

// Colour pattern field positions and values
`define PAT_LO_MSB 10
`define PAT_LO_LSB 7
`define PAT_HI_MSB 19
`define PAT_HI_LSB 16
`define PAT_MONO 4'h5
`define PAT_COLOUR 4'h3
`define COLOUR_PATTERN_RESET 20'h50280

// Reset values of the other registers and the accepted used-channel range
`define USED_CHANNELS_RESET 16'h0008
`define USED_CHANNELS_MIN 16'h0001
`define USED_CHANNELS_MAX 16'h0008
`define REG16_RESET 16'h0000

// Timing: core clock rate and longest lock time
`define CORE_CLK_MHZ 200
`define LOCK_TIME_MAX_US 1000

`endif

// ### hdl/sensor_pll_and_output_setup.v
// PLL programming, lock reporting, colour mode and output channel setup registers
//
// Contract
// RQ1: Colour select is bit 0 of bank 4 address 4; two fields of bank 1 address 118 reset to 5.
// RQ2: The host updates the colour fields by read-modify-write, keeping the other bits.
// RQ3: The host writes the dividers, releases core reset, waits 10 us, then powers up the PLL.
// RQ4: The host waits for lock, then writes the regulator value, then releases the wrapper reset.
// RQ5: The host computes the multiplier as floor(rate * 2^div / fin) with fin from 12 to 20 MHz.
// RQ6: The host picks the main divider exponent 3, 2 or 1 from the target rate band.
// RQ7: The host picks converter divider and regulator value per band and mode from the table.
// RQ8: The serial rate equals fin times the multiplier divided by two to the main divider.
// RQ9: Lock must arrive within 1 ms and is confirmed by polling the read-only status.
// RQ10: The lock status register reads 0 while out of lock and 1 once locked.
// RQ11: Sequencer 0 reports the bottom PLL lock and sequencer 1 reports the top PLL lock.
// RQ12: The host sets format 0, main divider 1, byte clock high 2 and byte clock low 1.
// RQ13: Channels carrying pixel data are never more than the used channels.
// RQ14: Every channel beyond the used-channel count is powered down.
// RQ15: The used-channel count accepts 1 to 8 and selects that many channels per side.
// RQ16: The host gives up and reports an error when lock has not shown after the longest time; the host model gives up after 100 status polls.
`timescale 1ns/1ps
`include "sensor_setup_defines.vh"

module sensor_pll_and_output_setup
#(
   parameter REF_CLK_KHZ = 12000,
   parameter NUM_CHANNELS = 8,
   parameter LOCK_TIMEOUT_CYC = `LOCK_TIME_MAX_US * `CORE_CLK_MHZ
)
(
   // Clock and reset
   input wire i_core_clk,
   input wire i_reset,
   // Register port behind the serial control interface
   input wire i_reg_write,
   input wire i_reg_read,
   input wire [2:0] i_reg_bank,
   input wire [6:0] i_reg_addr,
   input wire [19:0] i_reg_wdata,
   output reg [19:0] o_reg_rdata,
   output reg o_reg_rvalid,
   // Identity of this sequencer block
   input wire i_sequencer_identifier,
   // Lock indications from the two PLLs (asynchronous)
   input wire i_bottom_synth_lock,
   input wire i_top_synth_lock,
   // PLL controls
   output wire o_synth_power_up,
   output wire o_synth_core_reset_release,
   output wire o_synth_wrapper_reset_release,
   output wire [15:0] o_synth_feedback_multiplier,
   output wire [15:0] o_main_output_divider,
   output wire [15:0] o_converter_clock_divider,
   output wire [15:0] o_regulator_control,
   output reg [31:0] o_serial_rate_khz,
   output reg o_lock_timeout,
   // Colour and output format
   output wire o_colour_select,
   output wire [3:0] o_colour_pattern_low,
   output wire [3:0] o_colour_pattern_high,
   output wire [15:0] o_output_format_select,
   output wire [15:0] o_byte_clock_gen_high,
   output wire [15:0] o_byte_clock_gen_low,
   // Output channels per side
   input wire [NUM_CHANNELS-1:0] i_roi_channel_request,
   output reg [NUM_CHANNELS-1:0] o_channel_power_en,
   output reg [NUM_CHANNELS-1:0] o_channel_active
);

   reg colour_select_reg;
   reg [19:0] colour_pattern_fields_reg;
   reg [15:0] output_format_select_reg;
   reg [15:0] byte_clock_gen_high_reg;
   reg [15:0] byte_clock_gen_low_reg;
   reg [15:0] used_channel_count_reg;
   reg [15:0] synth_power_up_reg;
   reg [15:0] synth_feedback_multiplier_reg;
   reg [15:0] synth_core_reset_release_reg;
   reg [15:0] converter_clock_divider_reg;
   reg [15:0] main_output_divider_reg;
   reg [15:0] synth_wrapper_reset_release_reg;
   reg [15:0] regulator_control_reg;
   reg [2:0] bottom_sync_reg;
   reg [2:0] top_sync_reg;
   reg bottom_lock_reg;
   reg top_lock_reg;
   reg [31:0] lock_timer_reg;
   reg [19:0] read_next;
   wire wr_seq;
   wire wr_cfg;
   wire wr_ctx;
   wire selected_lock;
   wire [47:0] rate_product;
   wire [47:0] rate_shifted;

   assign wr_seq = i_reg_write && (i_reg_bank == `BANK_SEQ);
   assign wr_cfg = i_reg_write && (i_reg_bank == `BANK_CFG);
   assign wr_ctx = i_reg_write && (i_reg_bank == `BANK_CTX);

   // Register writes; an out-of-range used-channel count is ignored
   always @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         colour_select_reg <= 1'b0;
         colour_pattern_fields_reg <= `COLOUR_PATTERN_RESET; // RQ1
         output_format_select_reg <= `REG16_RESET;
         byte_clock_gen_high_reg <= `REG16_RESET;
         byte_clock_gen_low_reg <= `REG16_RESET;
         used_channel_count_reg <= `USED_CHANNELS_RESET;
         synth_power_up_reg <= `REG16_RESET;
         synth_feedback_multiplier_reg <= `REG16_RESET;
         synth_core_reset_release_reg <= `REG16_RESET;
         converter_clock_divider_reg <= `REG16_RESET;
         main_output_divider_reg <= `REG16_RESET;
         synth_wrapper_reset_release_reg <= `REG16_RESET;
         regulator_control_reg <= `REG16_RESET;
      end
      else
      begin
         if (wr_ctx && i_reg_addr == `ADDR_COLOUR_SELECT)
            colour_select_reg <= i_reg_wdata[0]; // RQ1
         if (wr_cfg && i_reg_addr == `ADDR_COLOUR_PATTERN)
            colour_pattern_fields_reg <= i_reg_wdata; // RQ2
         if (wr_cfg && i_reg_addr == `ADDR_BYTE_CLK_HIGH)
            byte_clock_gen_high_reg <= i_reg_wdata[15:0]; // RQ12
         if (wr_cfg && i_reg_addr == `ADDR_BYTE_CLK_LOW)
            byte_clock_gen_low_reg <= i_reg_wdata[15:0]; // RQ12
         if (wr_cfg && i_reg_addr == `ADDR_REGULATOR)
            regulator_control_reg <= i_reg_wdata[15:0]; // RQ4
         if (wr_seq && i_reg_addr == `ADDR_OUTPUT_FORMAT)
            output_format_select_reg <= i_reg_wdata[15:0]; // RQ12
         if (wr_seq && i_reg_addr == `ADDR_USED_CHANNELS &&
             i_reg_wdata[15:0] >= `USED_CHANNELS_MIN &&
             i_reg_wdata[15:0] <= `USED_CHANNELS_MAX)
            used_channel_count_reg <= i_reg_wdata[15:0]; // RQ15
         if (wr_seq && i_reg_addr == `ADDR_SYNTH_POWER_UP)
            synth_power_up_reg <= i_reg_wdata[15:0]; // RQ3
         if (wr_seq && i_reg_addr == `ADDR_SYNTH_FB_MULT)
            synth_feedback_multiplier_reg <= i_reg_wdata[15:0]; // RQ5
         if (wr_seq && i_reg_addr == `ADDR_SYNTH_CORE_RST)
            synth_core_reset_release_reg <= i_reg_wdata[15:0]; // RQ3
         if (wr_seq && i_reg_addr == `ADDR_CONV_CLK_DIV)
            converter_clock_divider_reg <= i_reg_wdata[15:0]; // RQ7
         if (wr_seq && i_reg_addr == `ADDR_MAIN_OUT_DIV)
            main_output_divider_reg <= i_reg_wdata[15:0]; // RQ6
         if (wr_seq && i_reg_addr == `ADDR_SYNTH_WRAP_RST)
            synth_wrapper_reset_release_reg <= i_reg_wdata[15:0]; // RQ4
      end
   end

   // Lock inputs pass three flip-flops; a change counts once stages two and three agree
   always @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         bottom_sync_reg <= 3'h0;
         top_sync_reg <= 3'h0;
         bottom_lock_reg <= 1'b0;
         top_lock_reg <= 1'b0;
      end
      else
      begin
         bottom_sync_reg <= {bottom_sync_reg[1:0], i_bottom_synth_lock};
         top_sync_reg <= {top_sync_reg[1:0], i_top_synth_lock};
         if (bottom_sync_reg[1] == bottom_sync_reg[2])
            bottom_lock_reg <= bottom_sync_reg[2];
         if (top_sync_reg[1] == top_sync_reg[2])
            top_lock_reg <= top_sync_reg[2];
      end
   end

   // Sequencer 0 reports the bottom PLL, sequencer 1 the top PLL
   assign selected_lock = i_sequencer_identifier ? top_lock_reg : bottom_lock_reg; // RQ11

   // Lock watchdog: counts from power-up until lock, flags the longest lock time
   always @(posedge i_core_clk)
   begin
      if (i_reset || !synth_power_up_reg[0] || selected_lock)
      begin
         lock_timer_reg <= 32'h0;
         o_lock_timeout <= 1'b0;
      end
      else if (lock_timer_reg >= LOCK_TIMEOUT_CYC[31:0] - 32'h1)
         o_lock_timeout <= 1'b1; // RQ9
      else
         lock_timer_reg <= lock_timer_reg + 32'h1;
   end

   // Read data, one cycle after the strobe; unmapped addresses read zero
   always @*
   begin
      read_next = 20'h0;
      if (i_reg_bank == `BANK_CTX && i_reg_addr == `ADDR_COLOUR_SELECT)
         read_next = {19'h0, colour_select_reg};
      else if (i_reg_bank == `BANK_CFG && i_reg_addr == `ADDR_COLOUR_PATTERN)
         read_next = colour_pattern_fields_reg; // RQ2
      else if (i_reg_bank == `BANK_CFG && i_reg_addr == `ADDR_BYTE_CLK_HIGH)
         read_next = {4'h0, byte_clock_gen_high_reg};
      else if (i_reg_bank == `BANK_CFG && i_reg_addr == `ADDR_BYTE_CLK_LOW)
         read_next = {4'h0, byte_clock_gen_low_reg};
      else if (i_reg_bank == `BANK_CFG && i_reg_addr == `ADDR_REGULATOR)
         read_next = {4'h0, regulator_control_reg};
      else if (i_reg_bank == `BANK_SEQ && i_reg_addr == `ADDR_OUTPUT_FORMAT)
         read_next = {4'h0, output_format_select_reg};
      else if (i_reg_bank == `BANK_SEQ && i_reg_addr == `ADDR_USED_CHANNELS)
         read_next = {4'h0, used_channel_count_reg};
      else if (i_reg_bank == `BANK_SEQ && i_reg_addr == `ADDR_SYNTH_POWER_UP)
         read_next = {4'h0, synth_power_up_reg};
      else if (i_reg_bank == `BANK_SEQ && i_reg_addr == `ADDR_SYNTH_FB_MULT)
         read_next = {4'h0, synth_feedback_multiplier_reg};
      else if (i_reg_bank == `BANK_SEQ && i_reg_addr == `ADDR_SYNTH_CORE_RST)
         read_next = {4'h0, synth_core_reset_release_reg};
      else if (i_reg_bank == `BANK_SEQ && i_reg_addr == `ADDR_SYNTH_LOCK)
         read_next = {19'h0, selected_lock}; // RQ10
      else if (i_reg_bank == `BANK_SEQ && i_reg_addr == `ADDR_CONV_CLK_DIV)
         read_next = {4'h0, converter_clock_divider_reg};
      else if (i_reg_bank == `BANK_SEQ && i_reg_addr == `ADDR_MAIN_OUT_DIV)
         read_next = {4'h0, main_output_divider_reg};
      else if (i_reg_bank == `BANK_SEQ && i_reg_addr == `ADDR_SYNTH_WRAP_RST)
         read_next = {4'h0, synth_wrapper_reset_release_reg};
   end

   always @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         o_reg_rdata <= 20'h0;
         o_reg_rvalid <= 1'b0;
      end
      else
      begin
         o_reg_rvalid <= i_reg_read;
         if (i_reg_read)
            o_reg_rdata <= read_next;
      end
   end

   // Resulting serial rate: fin times multiplier over two to the main divider
   assign rate_product = {16'h0, REF_CLK_KHZ[31:0]} * {32'h0, synth_feedback_multiplier_reg};
   assign rate_shifted = rate_product >> main_output_divider_reg[2:0];

   always @(posedge i_core_clk)
   begin
      if (i_reset)
         o_serial_rate_khz <= 32'h0;
      else
         o_serial_rate_khz <= rate_shifted[31:0]; // RQ8
   end

   // Per-channel power and activity: channels beyond the used count are off
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch = ch + 1)
      begin : g_channel
         always @(posedge i_core_clk)
         begin
            if (i_reset)
            begin
               o_channel_power_en[ch] <= 1'b0;
               o_channel_active[ch] <= 1'b0;
            end
            else
            begin
               o_channel_power_en[ch] <= (ch < used_channel_count_reg); // RQ14
               o_channel_active[ch] <= (ch < used_channel_count_reg) &&
                  i_roi_channel_request[ch]; // RQ13
            end
         end
      end
   endgenerate

   // Control outputs straight from their registers
   assign o_synth_power_up = synth_power_up_reg[0];
   assign o_synth_core_reset_release = synth_core_reset_release_reg[0];
   assign o_synth_wrapper_reset_release = synth_wrapper_reset_release_reg[0];
   assign o_synth_feedback_multiplier = synth_feedback_multiplier_reg;
   assign o_main_output_divider = main_output_divider_reg;
   assign o_converter_clock_divider = converter_clock_divider_reg;
   assign o_regulator_control = regulator_control_reg;
   assign o_colour_select = colour_select_reg;
   assign o_colour_pattern_low = colour_pattern_fields_reg[`PAT_LO_MSB:`PAT_LO_LSB];
   assign o_colour_pattern_high = colour_pattern_fields_reg[`PAT_HI_MSB:`PAT_HI_LSB];
   assign o_output_format_select = output_format_select_reg;
   assign o_byte_clock_gen_high = byte_clock_gen_high_reg;
   assign o_byte_clock_gen_low = byte_clock_gen_low_reg;

endmodule

// ### bench/sensor_setup_sva.sv
// Assertion checker of the PLL and output setup block, bound to its ports
`timescale 1ns/1ps
module sensor_setup_sva
#(
   parameter REF_CLK_KHZ = 12000,
   parameter NUM_CHANNELS = 8,
   parameter LOCK_TIMEOUT_CYC = 50
)
(
   // Clock, reset and register port
   input wire i_core_clk, input wire i_reset, input wire i_reg_write, input wire i_reg_read,
   input wire [2:0] i_reg_bank, input wire [6:0] i_reg_addr, input wire [19:0] i_reg_wdata,
   input wire [19:0] o_reg_rdata, input wire o_reg_rvalid,
   // Lock sources and PLL controls
   input wire i_sequencer_identifier, input wire i_bottom_synth_lock, input wire i_top_synth_lock,
   input wire o_synth_power_up, input wire [15:0] o_synth_feedback_multiplier,
   input wire [15:0] o_main_output_divider, input wire [31:0] o_serial_rate_khz,
   input wire o_lock_timeout,
   // Colour and channels
   input wire [3:0] o_colour_pattern_low, input wire [3:0] o_colour_pattern_high,
   input wire [NUM_CHANNELS-1:0] i_roi_channel_request,
   input wire [NUM_CHANNELS-1:0] o_channel_power_en, input wire [NUM_CHANNELS-1:0] o_channel_active
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   // Decoded accesses and expected values
   wire used_wr = i_reg_write && i_reg_bank == 3'h0 && i_reg_addr == 7'h0E;
   wire used_ok = i_reg_wdata[15:0] >= 16'h0001 && i_reg_wdata[15:0] <= 16'h0008;
   wire lock_rd = i_reg_read && i_reg_bank == 3'h0 && i_reg_addr == 7'h55;
   wire lock_sel = i_sequencer_identifier ? i_top_synth_lock : i_bottom_synth_lock;
   wire [3:0] wd4 = i_reg_wdata[3:0];
   wire wd0 = i_reg_wdata[0];
   wire [31:0] rate_calc =
      (REF_CLK_KHZ * o_synth_feedback_multiplier) >> o_main_output_divider[2:0];
   reg [31:0] pu_cnt;
   // Cycles spent with the PLL powered up
   always @(posedge i_core_clk)
      pu_cnt <= (i_reset || !o_synth_power_up) ? 32'h0 : pu_cnt + 32'h1;
   a_read_answer: assert property (i_reg_read |=> o_reg_rvalid)
      else $error("read not answered");
   a_lock_value: assert property
      (($stable(lock_sel) && $stable(i_sequencer_identifier))[*5] ##0 lock_rd
      |=> o_reg_rdata == {19'h0, $past(lock_sel)}) else $error("lock status wrong");
   a_used_power: assert property
      ((used_wr && used_ok) |-> ##2 o_channel_power_en == ((16'h1 << $past(wd4, 2)) - 16'h1))
      else $error("powered channels wrong");
   a_used_refused: assert property
      ((used_wr && !used_ok) |-> ##2 $stable(o_channel_power_en))
      else $error("bad count taken");
   a_active_used: assert property
      ((o_channel_active & ~o_channel_power_en & ~$past(o_channel_power_en)) == 8'h00)
      else $error("unused channel active");
   a_active_roi: assert property
      ((o_channel_active & ~$past(i_roi_channel_request)) == 8'h00)
      else $error("channel active outside region");
   a_rate_formula: assert property (o_serial_rate_khz == $past(rate_calc))
      else $error("serial rate wrong");
   a_timeout_wait: assert property
      (o_lock_timeout |-> $past(pu_cnt) >= LOCK_TIMEOUT_CYC - 3)
      else $error("lock timeout early");
   a_power_store: assert property
      ((i_reg_write && i_reg_bank == 3'h0 && i_reg_addr == 7'h4D)
      |=> o_synth_power_up == $past(wd0))
      else $error("power-up bit wrong");
   a_pattern_reset: assert property (disable iff (1'b0) i_reset |=>
      o_colour_pattern_low == 4'h5 && o_colour_pattern_high == 4'h5) else $error("pattern reset");
   c_lock_read: cover property (lock_rd ##1 o_reg_rdata[0]);
   c_used_write: cover property (used_wr && used_ok);
   c_timeout: cover property ($rose(o_lock_timeout));
endmodule
bind sensor_pll_and_output_setup sensor_setup_sva #(.REF_CLK_KHZ(REF_CLK_KHZ),
   .NUM_CHANNELS(NUM_CHANNELS), .LOCK_TIMEOUT_CYC(LOCK_TIMEOUT_CYC)) i_sva (.*);

// ### bench/sensor_host_model.sv
// Host controller model that drives the register port and runs the setup recipes
`timescale 1ns/1ps
module sensor_host_model
(
   // Clock
   input wire i_core_clk,
   // Register port towards the block
   output reg o_reg_write = 1'b0, output reg o_reg_read = 1'b0,
   output reg [2:0] o_reg_bank = 3'h7, output reg [6:0] o_reg_addr = 7'h7F,
   output reg [19:0] o_reg_wdata = 20'h0,
   input wire [19:0] i_reg_rdata, input wire i_reg_rvalid
);
   // One access; data line shows the inverse once released
   task wr(input [2:0] b, input [6:0] a, input [19:0] d);
   begin
      @(posedge i_core_clk) #1;
      {o_reg_bank, o_reg_addr, o_reg_wdata, o_reg_write} = {b, a, d, 1'b1};
      @(posedge i_core_clk) #1;
      {o_reg_wdata, o_reg_write} = {~d, 1'b0};
   end
   endtask
   task rd(input [2:0] b, input [6:0] a, output [19:0] q);
   begin
      @(posedge i_core_clk) #1;
      {o_reg_bank, o_reg_addr, o_reg_read} = {b, a, 1'b1};
      @(posedge i_core_clk) #1;
      o_reg_read = 1'b0;
      q = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 20'hFFFFF;
   end
   endtask
   // Bring-up; polling is bounded so a missing lock ends in a refusal
   task pll_up(input [15:0] mul, input [15:0] div, input [15:0] adc, input [15:0] rg, output ok);
      reg [19:0] q;
      integer n;
   begin
      wr(3'h0, 7'h4E, {4'h0, mul});
      wr(3'h0, 7'h56, {4'h0, adc});
      wr(3'h0, 7'h57, {4'h0, div});
      wr(3'h0, 7'h50, 20'h1);
      repeat (2000) @(posedge i_core_clk);
      wr(3'h0, 7'h4D, 20'h1);
      ok = 1'b0;
      for (n = 0; n < 100 && !ok; n = n + 1)
      begin
         rd(3'h0, 7'h55, q);
         ok = q[0];
      end
      if (ok)
      begin
         wr(3'h1, 7'h73, {4'h0, rg});
         wr(3'h0, 7'h58, 20'h1);
      end
   end
   endtask
   // Pattern fields changed while the other bits keep their value
   task rmw_colour(input [3:0] v);
      reg [19:0] q;
   begin
      rd(3'h1, 7'h76, q);
      wr(3'h1, 7'h76, {v, q[15:11], v, q[6:0]});
   end
   endtask
   task set_format;
   begin
      wr(3'h0, 7'h08, 20'h0);
      wr(3'h0, 7'h57, 20'h1);
      wr(3'h1, 7'h08, 20'h2);
      wr(3'h1, 7'h09, 20'h1);
   end
   endtask
endmodule

// ### bench/sensor_pll_and_output_setup_tb.sv
// Self-checking testbench of the PLL and output setup block
`timescale 1ns/1ps
module sensor_pll_and_output_setup_tb;
   reg clk = 1'b0, rst = 1'b1, sid = 1'b0, bot = 1'b0, top = 1'b0, ok;
   reg [7:0] roi = 8'h00;
   reg [19:0] q;
   wire rw, rr, rv, pu, crr, wrr, tmo, csel;
   wire [2:0] rb;
   wire [6:0] ra;
   wire [19:0] wd, rq;
   wire [15:0] mul, mdiv, adc, rg, fmt, bh, bl;
   wire [31:0] rate;
   wire [3:0] pl, ph;
   wire [7:0] pen, act;
   integer n_errors = 0, n_tests = 0;
   // Core clock at 200 MHz
   always #2.5 clk = ~clk;
   sensor_pll_and_output_setup #(.REF_CLK_KHZ(12000), .NUM_CHANNELS(8), .LOCK_TIMEOUT_CYC(50))
   i_dut (.i_core_clk(clk), .i_reset(rst), .i_reg_write(rw), .i_reg_read(rr), .i_reg_bank(rb),
      .i_reg_addr(ra), .i_reg_wdata(wd), .o_reg_rdata(rq), .o_reg_rvalid(rv),
      .i_sequencer_identifier(sid), .i_bottom_synth_lock(bot), .i_top_synth_lock(top),
      .o_synth_power_up(pu), .o_synth_core_reset_release(crr), .o_synth_wrapper_reset_release(wrr),
      .o_synth_feedback_multiplier(mul), .o_main_output_divider(mdiv),
      .o_converter_clock_divider(adc), .o_regulator_control(rg), .o_serial_rate_khz(rate),
      .o_lock_timeout(tmo), .o_colour_select(csel), .o_colour_pattern_low(pl),
      .o_colour_pattern_high(ph), .o_output_format_select(fmt), .o_byte_clock_gen_high(bh),
      .o_byte_clock_gen_low(bl), .i_roi_channel_request(roi), .o_channel_power_en(pen),
      .o_channel_active(act));
   sensor_host_model i_host (.i_core_clk(clk), .o_reg_write(rw), .o_reg_read(rr),
      .o_reg_bank(rb), .o_reg_addr(ra), .o_reg_wdata(wd), .i_reg_rdata(rq), .i_reg_rvalid(rv));
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   end
   endtask
   task final_report;
   begin
      if (n_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   // Land just after an edge so inputs never move on it
   task cyc(input integer n);
   begin
      repeat (n) @(posedge clk);
      #1;
   end
   endtask
   task t_reset;
   begin
      chk({ph, pl}, 8'h55);
      i_host.rd(3'h1, 7'h76, q);
      chk(q, 20'h50280);
      i_host.rd(3'h0, 7'h0E, q);
      chk({pen, q}, {8'hFF, 20'h8});
      i_host.rd(3'h0, 7'h55, q);
      chk(q, 20'h0);
   end
   endtask
   // 699 Mbit/s from 12 MHz, then main divider 1 from the format setup doubles the rate
   task t_pll;
   begin
      fork
         i_host.pll_up(16'h00E9, 16'h0002, 16'h0002, 16'h0015, ok);
         begin cyc(2040); bot = 1'b1; end
      join
      chk(ok, 1'b1);
      if (ok !== 1'b1) final_report;
      chk({wrr, rg}, {1'b1, 16'h0015});
      chk({crr, pu, adc}, {1'b1, 1'b1, 16'h0002});
      i_host.rd(3'h0, 7'h4E, q);
      chk(q, 20'h000E9);
      i_host.rd(3'h1, 7'h73, q);
      chk(q, 20'h00015);
      chk(rate, 32'h000AAA78);
      i_host.set_format;
      cyc(2);
      chk({mdiv, bl}, 32'h00010001);
      chk({fmt, bh}, 32'h00000002);
      chk(rate, 32'h001554F0);
   end
   endtask
   // Lock report follows the sequencer identifier
   task t_select;
   begin
      sid = 1'b1;
      cyc(6);
      i_host.rd(3'h0, 7'h55, q);
      chk(q, 20'h0);
      top = 1'b1;
      cyc(6);
      i_host.rd(3'h0, 7'h55, q);
      chk(q, 20'h1);
      {sid, bot} = 2'h0;
      cyc(6);
      i_host.rd(3'h0, 7'h55, q);
      chk(q, 20'h0);
   end
   endtask
   // Watchdog quiet for most of the limit, then raised within a bound
   task t_timeout;
      integer i;
   begin
      i_host.wr(3'h0, 7'h4D, 20'h0);
      i_host.wr(3'h0, 7'h4D, 20'h1);
      cyc(48);
      chk(tmo, 1'b0);
      for (i = 0; i < 4 && tmo !== 1'b1; i = i + 1)
         cyc(1);
      chk(tmo, 1'b1);
      if (tmo !== 1'b1) final_report;
      i_host.wr(3'h0, 7'h4D, 20'h0);
   end
   endtask
   task t_chan;
      integer k;
   begin
      roi = 8'hA5;
      i_host.wr(3'h0, 7'h0E, 20'h3);
      i_host.wr(3'h0, 7'h0E, 20'h0);
      i_host.wr(3'h0, 7'h0E, 20'h9);
      cyc(2);
      chk({pen, act}, 16'h0705);
      for (k = 1; k <= 8; k = k + 1)
      begin
         i_host.wr(3'h0, 7'h0E, k[19:0]);
         cyc(2);
         chk({pen, act}, {8'hFF >> (8 - k), 8'hA5 & (8'hFF >> (8 - k))});
      end
   end
   endtask
   task t_colour;
   begin
      i_host.wr(3'h4, 7'h04, 20'h1);
      chk(csel, 1'b1);
      i_host.rd(3'h4, 7'h04, q);
      chk(q, 20'h00001);
      i_host.wr(3'h1, 7'h76, 20'h51281);
      i_host.rmw_colour(4'h3);
      i_host.rd(3'h1, 7'h76, q);
      chk({ph, pl, q}, {8'h33, 20'h31181});
   end
   endtask
   initial
   begin
      cyc(12);
      rst = 1'b0;
      t_reset;
      t_pll;
      t_select;
      t_timeout;
      t_chan;
      t_colour;
      final_report;
   end
endmodule
